/* logic/sio_top.sv */
// sio_top: 8-bit clocked serial interface with nibble registers,
// AHB-Lite register slave and one level interrupt.
// assumes: single word transfers, OKAY only; shift clock and data in
// arrive asynchronously and are synchronised here.
// Function
// - 8-bit buffer, two nibble halves
// - clock source select, resets to slave
// - edge bit picks shift edge, reset 0
// - mask bit gates interrupt, reset 0
// - read-only flag marks finished transfer
// - reading the flag clears it
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/10ps
module sio_top
    import sio_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    input  wire logic        sclk_in,
    output logic             sclk_out,
    output logic             sclk_oe_b,
    input  wire logic        sdata_in,
    output logic             sdata_out
);

    typedef struct packed {
        sio_state_t  state;
        logic        wr_pend;
        logic [9:0]  wr_idx;
        logic [31:0] rdata;
        logic        ready;
        logic        resp;
        logic [7:0]  shreg;
        logic [3:0]  ctrl;
        logic        flag;
        logic [3:0]  bitcnt;
        logic [4:0]  togcnt;
        logic [5:0]  divcnt;
        logic        sclk;
        logic        sclk_oe_b;
        logic        sout;
        logic        irq;
    } sio_regs_t;

    localparam sio_regs_t SIO_REGS_RST = '{
        state:     SIO_IDLE,
        wr_pend:   1'b0,
        wr_idx:    10'h000,
        rdata:     32'h0000_0000,
        ready:     1'b1,
        resp:      1'b0,
        shreg:     8'h00,
        ctrl:      SIO_CTRL_RST,
        flag:      1'b0,
        bitcnt:    4'h0,
        togcnt:    5'h00,
        divcnt:    6'h00,
        sclk:      1'b1,
        sclk_oe_b: 1'b1,
        sout:      1'b0,
        irq:       1'b0
    };

    sio_regs_t   st;
    sio_regs_t   next_st;
    logic [1:0]  sy_level;
    logic [1:0]  sy_change;
    logic        acc;
    logic [9:0]  acc_idx;
    logic        busy;
    logic        master;
    logic        rise_ev;
    logic        fall_ev;
    logic        sample_ev;
    logic        launch_ev;
    logic        toggle_ev;
    logic        done_ev;
    logic [1:0]  sel;
    logic [5:0]  half;

    sio_sync #(
        .W (2)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .din     ({sdata_in, sclk_in}),
        .level   (sy_level),
        .change  (sy_change)
    );

    function automatic logic [31:0] rd_mux(
        input logic [9:0] idx,
        input logic [7:0] buf_v,
        input logic [3:0] ctrl_v,
        input logic       flag_v,
        input logic       busy_v
    );
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (idx)
            SIO_IDX_BUF_LO: d[3:0] = buf_v[3:0];
            SIO_IDX_BUF_HI: d[3:0] = buf_v[7:4];
            SIO_IDX_CTRL:   d[3:0] = ctrl_v;
            // bits 3..1 stay zero
            SIO_IDX_FLAG:   d[SIO_FLAG_BIT] = flag_v;
            SIO_IDX_RUN:    d[SIO_RUN_BIT] = busy_v;
            default:        d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    always_comb
    begin
        acc     = hsel && htrans[1] && hready;
        acc_idx = haddr[11:2];
        busy    = (st.state == SIO_SHIFT);
        sel     = st.ctrl[SIO_CTRL_SEL_LSB +: 2];
        master  = (sel != SIO_SEL_SLAVE);
        half    = sio_half_cycles(sel);
        toggle_ev = busy && master && (st.divcnt == half - 6'h01);
        if (master)
        begin
            rise_ev = toggle_ev && !st.sclk;
            fall_ev = toggle_ev && st.sclk;
        end
        else
        begin
            // level still holds the old value while change is high
            rise_ev = busy && sy_change[0] && !sy_level[0];
            fall_ev = busy && sy_change[0] && sy_level[0];
        end
        sample_ev = st.ctrl[SIO_CTRL_EDGE_BIT] ? fall_ev : rise_ev;
        launch_ev = st.ctrl[SIO_CTRL_EDGE_BIT] ? rise_ev : fall_ev;
        if (master)
        begin
            done_ev = toggle_ev && (st.togcnt == SIO_LAST_TOG);
        end
        else
        begin
            done_ev = sample_ev && (st.bitcnt == SIO_LAST_BIT);
        end

        next_st = st;
        next_st.ready   = 1'b1;
        next_st.resp    = 1'b0;
        next_st.wr_pend = acc && hwrite;
        next_st.wr_idx  = acc_idx;
        next_st.rdata   = 32'h0000_0000;

        if (acc && !hwrite)
        begin
            next_st.rdata = rd_mux(acc_idx, st.shreg, st.ctrl, st.flag,
                                   busy);
            if (acc_idx == SIO_IDX_FLAG)
            begin
                next_st.flag = 1'b0;
            end
        end

        if (st.wr_pend)
        begin
            unique case (st.wr_idx)
                SIO_IDX_BUF_LO:
                begin
                    // buffer is the shifter; writes while busy dropped
                    if (!busy)
                    begin
                        next_st.shreg[3:0] = hwdata[3:0];
                    end
                end
                SIO_IDX_BUF_HI:
                begin
                    if (!busy)
                    begin
                        next_st.shreg[7:4] = hwdata[3:0];
                    end
                end
                SIO_IDX_CTRL:
                begin
                    next_st.ctrl = hwdata[3:0];
                end
                SIO_IDX_RUN:
                begin
                    if (hwdata[SIO_RUN_BIT] && !busy)
                    begin
                        next_st.state     = SIO_SHIFT;
                        next_st.bitcnt    = 4'h0;
                        next_st.togcnt    = 5'h00;
                        next_st.divcnt    = 6'h00;
                        next_st.sclk      = 1'b1;
                        next_st.sout      = st.shreg[0];
                        next_st.sclk_oe_b = !master;
                    end
                    else if (!hwdata[SIO_RUN_BIT] && busy)
                    begin
                        // stop aborts without raising the flag
                        next_st.state     = SIO_IDLE;
                        next_st.divcnt    = 6'h00;
                        next_st.sclk      = 1'b1;
                        next_st.sclk_oe_b = 1'b1;
                    end
                end
                default:
                begin
                end
            endcase
        end

        if (busy && next_st.state == SIO_SHIFT)
        begin
            if (master)
            begin
                if (toggle_ev)
                begin
                    next_st.divcnt = 6'h00;
                    next_st.sclk   = !st.sclk;
                    next_st.togcnt = st.togcnt + 5'h01;
                end
                else
                begin
                    next_st.divcnt = st.divcnt + 6'h01;
                end
            end
            else
            begin
                // a mid-frame switch to slave lets go of the clock pin
                next_st.sclk_oe_b = 1'b1;
            end
            if (sample_ev)
            begin
                next_st.shreg  = {sy_level[1], st.shreg[7:1]};
                next_st.bitcnt = st.bitcnt + 4'h1;
            end
            if (launch_ev)
            begin
                next_st.sout = st.shreg[0];
            end
            if (done_ev)
            begin
                next_st.state     = SIO_IDLE;
                next_st.sclk      = 1'b1;
                next_st.sclk_oe_b = 1'b1;
                // set after the read clear so a coinciding event stays
                next_st.flag      = 1'b1;
            end
        end

        next_st.irq = next_st.flag && next_st.ctrl[SIO_CTRL_MASK_BIT];
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= SIO_REGS_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign hrdata    = st.rdata;
    assign hreadyout = st.ready;
    assign hresp     = st.resp;
    assign irq       = st.irq;
    assign sclk_out  = st.sclk;
    assign sclk_oe_b = st.sclk_oe_b;
    assign sdata_out = st.sout;

    default clocking sio_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    chk_buf_low_write: assert property (
        st.wr_pend && st.wr_idx == SIO_IDX_BUF_LO && !busy
        |=> st.shreg[3:0] == $past(hwdata[3:0]))
        else $error("buffer low nibble not written");

    chk_clk_half_period: assert property (
        busy && master && $stable(st.ctrl) && $past(busy)
        && $changed(st.sclk)
        |-> $past(st.divcnt) == half - 6'h01)
        else $error("shift clock half period wrong");

    chk_edge_no_shift: assert property (
        busy && !sample_ev && !st.wr_pend |=> $stable(st.bitcnt))
        else $error("shift on unselected edge");

    chk_irq_mask_gate: assert property (
        done_ev && !st.wr_pend |=> irq == st.ctrl[SIO_CTRL_MASK_BIT])
        else $error("interrupt not gated by mask");

    chk_flag_on_done: assert property (
        done_ev && !st.wr_pend |=> st.flag && !busy ##1 st.flag || $past(acc))
        else $error("flag not raised at transfer end");

    chk_flag_upper_zero: assert property (
        acc && !hwrite && acc_idx == SIO_IDX_FLAG
        |=> hrdata[3:1] == 3'h0 && hrdata[0] == $past(st.flag))
        else $error("flag nibble upper bits not zero");

    chk_flag_read_clear: assert property (
        acc && !hwrite && acc_idx == SIO_IDX_FLAG && !done_ev
        |=> !st.flag)
        else $error("flag not cleared by read");

    chk_slave_no_drive: assert property (
        busy && !master && $stable(st.ctrl)
        |-> sclk_oe_b && $stable(st.divcnt))
        else $error("clock driven in slave mode");

endmodule // sio_top

/* logic/sio_pkg.sv */
// sio_pkg: register map, field layout, reset values and shift timing
// for the nibble-wide serial interface block.
// assumes: word-aligned AHB-Lite access, byte address = 4 * index.
package sio_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] SIO_IDX_RUN    = 10'h2EC;
    localparam logic [9:0] SIO_IDX_BUF_LO = 10'h2F0;
    localparam logic [9:0] SIO_IDX_BUF_HI = 10'h2F1;
    localparam logic [9:0] SIO_IDX_CTRL   = 10'h2F2;
    localparam logic [9:0] SIO_IDX_FLAG   = 10'h2F3;

    // control nibble layout
    localparam int SIO_CTRL_MASK_BIT = 0;
    localparam int SIO_CTRL_EDGE_BIT = 1;
    localparam int SIO_CTRL_SEL_LSB  = 2;
    localparam int SIO_FLAG_BIT      = 0;
    localparam int SIO_RUN_BIT       = 0;

    // both clock-source bits set, edge and mask clear
    localparam logic [3:0] SIO_CTRL_RST = 4'hC;

    localparam logic [1:0] SIO_SEL_BASE  = 2'h0;
    localparam logic [1:0] SIO_SEL_HALF  = 2'h1;
    localparam logic [1:0] SIO_SEL_SLAVE = 2'h3;

    // base shift clock half period in ref_clk cycles
    localparam logic [5:0] SIO_BASE_HALF = 6'h08;
    localparam logic [3:0] SIO_LAST_BIT  = 4'h7;
    localparam logic [4:0] SIO_LAST_TOG  = 5'h0F;

    typedef enum logic {SIO_IDLE, SIO_SHIFT} sio_state_t;

    // half period of the internal shift clock for a source selection
    function automatic logic [5:0] sio_half_cycles(input logic [1:0] sel);
        logic [5:0] h;
        h = SIO_BASE_HALF;
        unique case (sel)
            SIO_SEL_BASE: h = SIO_BASE_HALF;
            SIO_SEL_HALF: h = {SIO_BASE_HALF[4:0], 1'b0};
            default:      h = {SIO_BASE_HALF[3:0], 2'b00};
        endcase
        return h;
    endfunction

endpackage

/* logic/sio_sync.sv */
// sio_sync: three-stage synchroniser with agreement filter.
// assumes: inputs asynchronous to ref_clk; a change is accepted once
// the second and third stages agree.
`timescale 1ns/10ps
module sio_sync #(
    parameter int W = 2
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] level,
    output logic      [W-1:0] change
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sio_sync_t;

    sio_sync_t st;
    sio_sync_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st.s2[i] == st.s3[i])
            begin
                next_st.lvl[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // idle shift clock sits high
            st <= '1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign level  = st.lvl;
    assign change = ~(st.s2 ^ st.s3) & (st.s3 ^ st.lvl);

endmodule // sio_sync

/* sim/sio_peer.sv */
// sio_peer: far-side serial device; follows the block's shift clock
// in master mode and makes the shift clock itself in slave mode.
// assumes: idle clock high, LSB first, the block's edge mapping.
`timescale 1ns/10ps
module sio_peer (
    input  wire logic sclk_out,
    input  wire logic sclk_oe_b,
    input  wire logic sdata_out,
    output logic      sclk_in,
    output logic      sdata_in
);
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    logic       edge_sel = 1'b0;
    logic       act = 1'b0;
    int         cnt = 0;

    initial
    begin
        sclk_in = 1'b1;
        sdata_in = 1'b0;
    end

    always @(negedge sclk_oe_b)
    begin
        act = 1'b1;
        cnt = 0;
        sdata_in = tx[0];
    end

    // edge_sel low: sample on rising, launch on falling
    always @(sclk_out)
    begin
        if (act && sclk_out === ~edge_sel)
        begin
            rx[cnt] = sdata_out;
            cnt++;
            act = (cnt < 8);
            // released line must not keep the last bit
            if (!act)
                sdata_in = ~sdata_in;
        end
        else if (act)
            sdata_in = tx[cnt];
    end

    // slave mode: this side owns the clock, falling-edge launch only
    task automatic frame(input logic [7:0] d);
        tx = d;
        sdata_in = d[0];
        for (int i = 0; i < 8; i++)
        begin
            #100;
            if (i > 0)
                rx[i-1] = sdata_out;
            sclk_in = 1'b0;
            sdata_in = d[i];
            #100;
            sclk_in = 1'b1;
        end
        #100;
        rx[7] = sdata_out;
        sdata_in = ~sdata_in;
    endtask
endmodule // sio_peer

/* sim/sio_top_test.sv */
// sio_top_test: self-checking bench for the serial interface block.
// assumes: sio_peer on the serial pins, one AHB-Lite master here.
`timescale 1ns/10ps
module sio_top_test
    import sio_pkg::*;
;
    logic        ref_clk;
    logic        rst_b;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic        sclk_in;
    logic        sclk_out;
    logic        sclk_oe_b;
    logic        sdata_in;
    logic        sdata_out;
    logic        rd_phase;
    logic [31:0] rng;
    logic [31:0] exp_q[$];
    string       name_q[$];
    int          err_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    logic [3:0]  cfg [5] = '{4'h0, 4'h7, 4'h9, 4'h3, 4'hD};

    sio_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe_b(sclk_oe_b),
        .sdata_in(sdata_in), .sdata_out(sdata_out));
    sio_peer peer (.sclk_out(sclk_out), .sclk_oe_b(sclk_oe_b),
        .sdata_out(sdata_out), .sclk_in(sclk_in), .sdata_in(sdata_in));

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] s);
        num_checks++;
        if (s !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    // read data is judged where it appears, against the oldest note
    always @(posedge ref_clk)
    begin
        if (rd_phase && hreadyout === 1'b1)
        begin
            check(name_q.pop_front(), exp_q.pop_front(), hrdata);
            check("hresp", 32'h0, {31'h0, hresp});
        end
    end

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic bus(input logic [9:0] idx, input logic wr,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {20'h0, idx, 2'b00};
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans   <= 2'h0;
        hwdata   <= d;
        rd_phase <= !wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd_phase <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [3:0] nib);
        logic [31:0] r;
        r = xs();
        bus(idx, 1'b1, {r[31:4], nib});
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] e,
                      input string nm);
        exp_q.push_back(e);
        name_q.push_back(nm);
        bus(idx, 1'b0, xs());
    endtask

    // one frame per control setting; flag, irq and data judged after
    task automatic xfer(input logic [3:0] c);
        logic [31:0] t;
        logic [31:0] p;
        int          n;
        int          h;
        t = xs();
        p = xs();
        n = 0;
        h = int'(SIO_BASE_HALF) << c[3:2];
        wr(SIO_IDX_CTRL, c);
        wr(SIO_IDX_BUF_LO, t[3:0]);
        wr(SIO_IDX_BUF_HI, t[7:4]);
        rd(SIO_IDX_BUF_HI, {28'h0, t[7:4]}, "buf hi");
        peer.tx = p[7:0];
        peer.edge_sel = c[SIO_CTRL_EDGE_BIT];
        wr(SIO_IDX_RUN, 4'h1);
        if (c[3:2] == SIO_SEL_SLAVE)
        begin
            repeat (40) @(posedge ref_clk);
            rd(SIO_IDX_FLAG, 32'h0, "flag no clk");
            #13 peer.frame(p[7:0]);
            do @(posedge ref_clk); while (irq !== 1'b1 && ++n < 20);
        end
        else
        begin
            do @(posedge ref_clk); while (sclk_oe_b !== 1'b1 && ++n < 1100);
            check("frame len", 32'h1, {31'h0, n >= 16*h-2 && n <= 16*h+2});
        end
        check("irq set", {31'h0, c[0]}, {31'h0, irq});
        rd(SIO_IDX_FLAG, 32'h1, "flag set");
        rd(SIO_IDX_FLAG, 32'h0, "flag clr");
        check("irq clr", 32'h0, {31'h0, irq});
        rd(SIO_IDX_BUF_LO, {28'h0, p[3:0]}, "rx lo");
        rd(SIO_IDX_BUF_HI, {28'h0, p[7:4]}, "rx hi");
        check("peer rx", {24'h0, t[7:0]}, {24'h0, peer.rx});
    endtask

    initial
    begin
        logic [31:0] v;
        rng = 32'h7AE84BBD;
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        rd_phase = 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        rd(SIO_IDX_CTRL, {28'h0, SIO_CTRL_RST}, "ctrl rst");
        rd(SIO_IDX_FLAG, 32'h0, "flag rst");
        v = xs();
        wr(SIO_IDX_CTRL, v[3:0]);
        rd(SIO_IDX_CTRL, {28'h0, v[3:0]}, "ctrl rw");
        wr(10'h3FF, v[7:4]);
        rd(10'h3FF, 32'h0, "unmapped");
        foreach (cfg[i])
            xfer(cfg[i]);
        tally_and_finish();
    end
endmodule // sio_top_test
